/* File: hdl/bdc_core.sv */
// Contract
// - both inputs high brakes via slow decay
// - brake holds while both inputs stay high
// - synchronous rectification on at decay start
// - zero current turns rectification off
// - trip gives fast decay, half off-time
// - slow decay for off-time remainder
// - all drivers off for dead time
// - no rectification during dead time
// - constant off-time of 25 us
// - trip resets latch, diagonal pair off
// - input decode; coast, standby after 1 ms
`include "bdc_defines.svh"
module bdc_core #(
  parameter int TOFF_CYC  = `BDC_TOFF_CYC,   // Off-time in cycles
  parameter int TCOD_CYC  = `BDC_TCOD_CYC,   // Dead time in cycles
  parameter int TSTBY_CYC = `BDC_TSTBY_CYC   // Standby delay in cycles
) (
  input  wire logic          core_clk_i,       // 20 MHz clock
  input  wire logic          rst_n_i,          // Sync reset, active low
  input  wire logic          drive_input_a_i,  // Pin input A
  input  wire logic          drive_input_b_i,  // Pin input B
  input  wire logic          current_trip_i,   // Sense comparator trip (pin domain)
  input  wire logic          zero_current_i,   // Zero-current detect (pin domain)
  output bdc_pkg::bdc_leg_t  bridge_output_a_o, // Gates of output A leg
  output bdc_pkg::bdc_leg_t  bridge_output_b_o, // Gates of output B leg
  output logic               sync_rect_o,      // Rectification active
  output logic               standby_o,        // Low-power standby
  output bdc_pkg::bdc_state_t state_o          // Bridge state
);
  import bdc_pkg::*;

  localparam logic [`BDC_CNT_W-1:0] TOFF_C  = TOFF_CYC[`BDC_CNT_W-1:0];
  localparam logic [`BDC_CNT_W-1:0] FAST_C  = 16'((TOFF_CYC * `BDC_FAST_PCT) / 100);
  localparam logic [`BDC_CNT_W-1:0] TCOD_C  = TCOD_CYC[`BDC_CNT_W-1:0];
  localparam logic [`BDC_CNT_W-1:0] TSTBY_C = TSTBY_CYC[`BDC_CNT_W-1:0];

  logic [3:0] raw;
  logic [3:0] syn;
  assign raw = {zero_current_i, current_trip_i, drive_input_b_i, drive_input_a_i};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_sync
      bdc_sync u_sync (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .async_i    (raw[g]),
        .sync_o     (syn[g])
      );
    end
  endgenerate

  wire in_a  = syn[0];
  wire in_b  = syn[1];
  wire trip  = syn[2];
  wire zero  = syn[3];
  wire fwd   = in_a & ~in_b;
  wire rev   = ~in_a & in_b;
  wire brake = in_a & in_b;
  wire coast = ~in_a & ~in_b;

  bdc_state_t               state_reg, state_next;
  logic [`BDC_CNT_W-1:0]    off_cnt_reg, off_cnt_next;
  logic [`BDC_CNT_W-1:0]    cod_cnt_reg, cod_cnt_next;
  logic [`BDC_CNT_W-1:0]    stb_cnt_reg, stb_cnt_next;
  logic                     dir_fwd_reg, dir_fwd_next;
  logic                     sr_reg, sr_next;

  wire off_done  = (off_cnt_reg >= TOFF_C - `BDC_ONE);
  wire fast_done = (off_cnt_reg >= FAST_C - `BDC_ONE);
  wire cod_done  = (cod_cnt_reg >= TCOD_C - `BDC_ONE);
  wire stb_done  = (stb_cnt_reg >= TSTBY_C - `BDC_ONE);
  wire drive_sel = fwd | rev;

  // Off-time keeps counting through the dead time so the period stays fixed
  wire in_decay = (state_reg == BDC_S_FAST) | (state_reg == BDC_S_DEAD) | (state_reg == BDC_S_SLOW);

  always_comb begin
    state_next   = state_reg;
    dir_fwd_next = dir_fwd_reg;
    cod_cnt_next = `BDC_ZERO;
    off_cnt_next = in_decay ? `BDC_CNT_W'(off_cnt_reg + `BDC_ONE) : `BDC_ZERO;
    stb_cnt_next = (coast && !stb_done) ? `BDC_CNT_W'(stb_cnt_reg + `BDC_ONE) : (coast ? stb_cnt_reg : `BDC_ZERO);
    sr_next      = 1'b0;
    case (state_reg)
      BDC_S_COAST, BDC_S_STBY: begin
        if (brake) begin
          state_next = BDC_S_BRAKE;
        end else if (drive_sel) begin
          state_next   = BDC_S_DRIVE;
          dir_fwd_next = fwd;
        end else if (stb_done) begin
          state_next = BDC_S_STBY;
        end
      end
      BDC_S_DRIVE: begin
        dir_fwd_next = fwd;
        if (brake) begin
          state_next = BDC_S_BRAKE;
        end else if (coast) begin
          state_next = BDC_S_COAST;
        end else if (trip) begin
          state_next = BDC_S_FAST;
          sr_next    = ~zero;
        end
      end
      BDC_S_FAST: begin
        sr_next = sr_reg & ~zero;
        if (fast_done) begin
          state_next = BDC_S_DEAD;
          sr_next    = 1'b0;
        end
      end
      BDC_S_DEAD: begin
        cod_cnt_next = `BDC_CNT_W'(cod_cnt_reg + `BDC_ONE);
        sr_next      = 1'b0;
        if (cod_done) begin
          state_next = BDC_S_SLOW;
          sr_next    = ~zero;
        end
      end
      BDC_S_SLOW: begin
        sr_next = sr_reg & ~zero;
        if (off_done) begin
          sr_next = 1'b0;
          if (brake) begin
            state_next = BDC_S_BRAKE;
          end else if (drive_sel) begin
            state_next   = BDC_S_DRIVE;
            dir_fwd_next = fwd;
          end else begin
            state_next = BDC_S_COAST;
          end
        end
      end
      BDC_S_BRAKE: begin
        if (!brake) begin
          state_next   = coast ? BDC_S_COAST : BDC_S_DRIVE;
          dir_fwd_next = fwd;
        end
      end
      default: begin
        state_next = BDC_S_COAST;
      end
    endcase
  end

  // Leg gate decode from the next state, so the outputs are registered
  wire nd_drive = (state_next == BDC_S_DRIVE);
  wire nd_fast  = (state_next == BDC_S_FAST);
  wire nd_slow  = (state_next == BDC_S_SLOW) | (state_next == BDC_S_BRAKE);
  // Fast decay reverses the diagonal; only with rectification are gates on,
  // otherwise the body diodes carry the current.
  wire fa_hs = nd_drive & dir_fwd_next | nd_fast & sr_next & ~dir_fwd_next;
  wire fa_ls = nd_drive & ~dir_fwd_next | nd_fast & sr_next & dir_fwd_next;
  wire fb_hs = nd_drive & ~dir_fwd_next | nd_fast & sr_next & dir_fwd_next;
  wire fb_ls = nd_drive & dir_fwd_next | nd_fast & sr_next & ~dir_fwd_next;
  // Slow decay: both low sides; brake keeps them on regardless of current
  wire sl_on = (state_next == BDC_S_BRAKE) | (nd_slow & sr_next);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_reg         <= BDC_S_COAST;
      off_cnt_reg       <= `BDC_ZERO;
      cod_cnt_reg       <= `BDC_ZERO;
      stb_cnt_reg       <= `BDC_ZERO;
      dir_fwd_reg       <= 1'b0;
      sr_reg            <= 1'b0;
      bridge_output_a_o <= '0;
      bridge_output_b_o <= '0;
      sync_rect_o       <= 1'b0;
      standby_o         <= 1'b0;
      state_o           <= BDC_S_COAST;
    end else begin
      state_reg         <= state_next;
      off_cnt_reg       <= off_cnt_next;
      cod_cnt_reg       <= cod_cnt_next;
      stb_cnt_reg       <= stb_cnt_next;
      dir_fwd_reg       <= dir_fwd_next;
      sr_reg            <= sr_next;
      bridge_output_a_o <= '{hs: fa_hs, ls: fa_ls | sl_on};
      bridge_output_b_o <= '{hs: fb_hs, ls: fb_ls | sl_on};
      sync_rect_o       <= sr_next;
      standby_o         <= (state_next == BDC_S_STBY);
      state_o           <= state_next;
    end
  end
endmodule : bdc_core

/* File: hdl/bdc_defines.svh */
`ifndef BDC_DEFINES_SVH
`define BDC_DEFINES_SVH
// Clock rate in Hz
`define BDC_CLK_HZ        20000000
// Nominal constant off-time, ns
`define BDC_TOFF_NS       25000
// Crossover dead time, ns (typical)
`define BDC_TCOD_NS       400
// Standby delay, us
`define BDC_TSTBY_US      1000
// Off-time, rounded down to whole cycles
`define BDC_TOFF_CYC      ((`BDC_TOFF_NS * (`BDC_CLK_HZ / 1000000)) / 1000)
// Dead time is a least time: round up
`define BDC_TCOD_CYC      ((`BDC_TCOD_NS * (`BDC_CLK_HZ / 1000000) + 999) / 1000)
`define BDC_TSTBY_CYC     (`BDC_TSTBY_US * (`BDC_CLK_HZ / 1000000))
`define BDC_FAST_PCT      50
`define BDC_CNT_W         16
`define BDC_ONE           16'h0001
`define BDC_ZERO          16'h0000
`endif

/* File: hdl/bdc_pkg.sv */
`include "bdc_defines.svh"
package bdc_pkg;
  // Bridge leg drive: high-side and low-side gate for one output
  typedef struct packed {
    logic hs;
    logic ls;
  } bdc_leg_t;

  typedef enum logic [6:0] {
    BDC_S_COAST = 7'b0000001,
    BDC_S_DRIVE = 7'b0000010,
    BDC_S_FAST  = 7'b0000100,
    BDC_S_DEAD  = 7'b0001000,
    BDC_S_SLOW  = 7'b0010000,
    BDC_S_BRAKE = 7'b0100000,
    BDC_S_STBY  = 7'b1000000
  } bdc_state_t;
endpackage : bdc_pkg

/* File: hdl/bdc_sync.sv */
// Three-stage input synchroniser: output moves once stages two and three agree
module bdc_sync (
  input  wire logic core_clk_i,  // Clock
  input  wire logic rst_n_i,     // Sync reset, active low
  input  wire logic async_i,     // Pin input
  output logic      sync_o       // Filtered level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  wire  agree = (s2_reg == s3_reg);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (agree) begin
        sync_o <= s3_reg;
      end
    end
  end
endmodule : bdc_sync

/* File: verif/bdc_core_properties.sv */
module bdc_core_properties #(
  parameter int TOFF_CYC = 40, // Off-time cycles
  parameter int TCOD_CYC = 8   // Dead time cycles
) (
  input wire logic                core_clk_i,        // Clock
  input wire logic                rst_n_i,           // Sync reset
  input wire bdc_pkg::bdc_leg_t   bridge_output_a_o, // Leg A gates
  input wire bdc_pkg::bdc_leg_t   bridge_output_b_o, // Leg B gates
  input wire logic                sync_rect_o,       // Rectifying
  input wire logic                standby_o,         // Standby
  input wire bdc_pkg::bdc_state_t state_o            // State
);
  import bdc_pkg::*;
  logic [15:0] run_reg;
  logic [15:0] dead_reg;
  wire dec = state_o inside {BDC_S_FAST, BDC_S_DEAD, BDC_S_SLOW};
  wire off = bridge_output_a_o == 2'h0 && bridge_output_b_o == 2'h0;
  wire la  = bridge_output_a_o == 2'h1 && bridge_output_b_o == 2'h1;
  always_ff @(posedge core_clk_i) begin
    run_reg  <= dec ? run_reg + 16'h0001 : 16'h0000;
    dead_reg <= (state_o == BDC_S_DEAD) ? dead_reg + 16'h0001 : 16'h0000;
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_dead_gates_off: assert property (state_o == BDC_S_DEAD |-> off)
    else $error("gate on in dead time");
  chk_dead_no_rect: assert property (state_o == BDC_S_DEAD |-> !sync_rect_o)
    else $error("rectifier on in dead time");
  chk_fast_half: assert property ($fell(state_o == BDC_S_FAST) |->
    state_o == BDC_S_DEAD && run_reg inside {[TOFF_CYC/2-1:TOFF_CYC/2+1]})
    else $error("fast decay length wrong");
  chk_dead_length: assert property ($fell(state_o == BDC_S_DEAD) |->
    state_o == BDC_S_SLOW && dead_reg == TCOD_CYC)
    else $error("dead time length wrong");
  chk_off_total: assert property ($fell(state_o == BDC_S_SLOW) |->
    !dec && run_reg inside {[TOFF_CYC-1:TOFF_CYC+1]})
    else $error("off-time length wrong");
  chk_fast_gates: assert property (state_o == BDC_S_FAST |-> (sync_rect_o ?
    bridge_output_a_o == ~bridge_output_b_o && bridge_output_a_o != 2'h3 && !off : off))
    else $error("fast decay gates wrong");
  chk_slow_gates: assert property (state_o == BDC_S_SLOW |-> (sync_rect_o ? la : off))
    else $error("slow decay gates wrong");
  chk_brake_low: assert property (state_o == BDC_S_BRAKE |-> la)
    else $error("brake gates wrong");
  chk_stby_idle: assert property (standby_o |-> state_o == BDC_S_STBY && off)
    else $error("standby with gates on");
  chk_trip_source: assert property ($rose(state_o == BDC_S_FAST) |-> $past(state_o) == BDC_S_DRIVE)
    else $error("fast decay not from drive");
endmodule : bdc_core_properties

bind bdc_core bdc_core_properties #(.TOFF_CYC(TOFF_CYC), .TCOD_CYC(TCOD_CYC)) i_bdc_core_properties (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .bridge_output_a_o(bridge_output_a_o),
  .bridge_output_b_o(bridge_output_b_o), .sync_rect_o(sync_rect_o), .standby_o(standby_o), .state_o(state_o));

/* File: verif/bdc_pwm_model.sv */
module bdc_pwm_model (
  input  wire logic       core_clk_i,      // Clock
  input  wire logic [1:0] cmd_i,           // Wanted {a,b}
  output logic            drive_input_a_o, // Pin A
  output logic            drive_input_b_o  // Pin B
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {drive_input_a_o, drive_input_b_o} = 2'h0;
  // Pins move on the falling edge so the core never samples mid-change
  always @(negedge core_clk_i) begin
    {drive_input_a_o, drive_input_b_o} <= cmd_i;
  end
endmodule : bdc_pwm_model

/* File: verif/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import bdc_pkg::*;
  logic core_clk_i, rst_n_i, trip, zero, a_pin, b_pin, sr, stby;
  logic [1:0] cmd;
  bdc_leg_t leg_a, leg_b;
  bdc_state_t st;
  bdc_state_t last_st = BDC_S_COAST;
  logic [10:0] exp_q[$];
  int err_count, samples_checked, seed, k, dir;
  bdc_pwm_model i_bdc_pwm_model (.core_clk_i(core_clk_i), .cmd_i(cmd), .drive_input_a_o(a_pin),
    .drive_input_b_o(b_pin));
  bdc_core #(.TOFF_CYC(40), .TCOD_CYC(8), .TSTBY_CYC(20)) i_bdc_core (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .drive_input_a_i(a_pin), .drive_input_b_i(b_pin), .current_trip_i(trip),
    .zero_current_i(zero), .bridge_output_a_o(leg_a), .bridge_output_b_o(leg_b), .sync_rect_o(sr),
    .standby_o(stby), .state_o(st));
  initial begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  task automatic check(input logic [10:0] seen, input logic [10:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask : check
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  task automatic wait_st(input bdc_state_t s);
    int n;
    n = 0;
    while (st !== s && n < 2000) begin
      @(negedge core_clk_i);
      n++;
    end
    if (st !== s) begin
      err_count++;
      give_verdict();
    end
  endtask : wait_st
  // Every state change is paired with the oldest expected note
  always @(negedge core_clk_i) begin
    if (rst_n_i && st !== last_st) begin
      check({st, leg_a, leg_b}, exp_q.size() ? exp_q.pop_front() : 11'h000);
    end
    last_st = st;
  end
  task automatic chop(input logic fwd, input logic zc);
    logic [3:0] on;
    on = fwd ? 4'h9 : 4'h6;
    zero = zc;
    repeat (6) @(negedge core_clk_i);
    exp_q.push_back({BDC_S_FAST, zc ? 4'h0 : ~on});
    exp_q.push_back({BDC_S_DEAD, 4'h0});
    exp_q.push_back({BDC_S_SLOW, zc ? 4'h0 : 4'h5});
    exp_q.push_back({BDC_S_DRIVE, on});
    trip = 1'b1;
    wait_st(BDC_S_FAST);
    check({10'h000, sr}, {10'h000, ~zc});
    trip = 1'b0;
    wait_st(BDC_S_DRIVE);
  endtask : chop
  initial begin
    seed = 32'hEC25BB37;
    rst_n_i = 1'b0;
    trip = 1'b0;
    zero = 1'b0;
    cmd = 2'h2;
    exp_q.push_back({BDC_S_DRIVE, 4'h9});
    repeat (16) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    wait_st(BDC_S_DRIVE);
    for (k = 0; k < 8; k++) begin
      dir = $random(seed);
      chop(cmd[1], dir[1]);
      exp_q.push_back({BDC_S_BRAKE, 4'h5});
      cmd = 2'h3;
      wait_st(BDC_S_BRAKE);
      repeat (12) @(negedge core_clk_i);
      exp_q.push_back({BDC_S_DRIVE, dir[0] ? 4'h9 : 4'h6});
      cmd = dir[0] ? 2'h2 : 2'h1;
      wait_st(BDC_S_DRIVE);
    end
    exp_q.push_back({BDC_S_COAST, 4'h0});
    exp_q.push_back({BDC_S_STBY, 4'h0});
    cmd = 2'h0;
    wait_st(BDC_S_STBY);
    check({10'h000, stby}, 11'h001);
    give_verdict();
  end
endmodule : tb_top
